//--- verilog/plmc_cfg.svh
`ifndef PLMC_CFG_SVH
`define PLMC_CFG_SVH

// ----------------------------------------------------------------------------
// reset values and filter figures
// ----------------------------------------------------------------------------
`define PLMC_STORE_RST   1'h0
`define PLMC_LEVEL_RST   1'h0
`define PLMC_SYNC_RST    3'h0
`define PLMC_SYNC_DEPTH  3
`define PLMC_NUM_PADS    3
`define PLMC_PAD_FIRST   0
`define PLMC_PAD_SECOND  1
`define PLMC_PAD_ARRAY   2

`endif

//--- verilog/plmc_pkg.sv
package plmc_pkg;

  // --------------------------------------------------------------------------
  // static configuration encodings
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    PLMC_STORE_LATCH = 1'h0,
    PLMC_STORE_FLOP  = 1'h1
  } plmc_store_mode_e;

  typedef enum logic [1:0] {
    PLMC_CLK_NET_ZERO = 2'h0,
    PLMC_CLK_NET_ONE  = 2'h1,
    PLMC_CLK_ARRAY    = 2'h2
  } plmc_clk_sel_e;

  typedef enum logic [1:0] {
    PLMC_SRC_PAD_FIRST  = 2'h0,
    PLMC_SRC_PAD_SECOND = 2'h1,
    PLMC_SRC_INT_FIRST  = 2'h2,
    PLMC_SRC_INT_SECOND = 2'h3
  } plmc_net_src_e;

endpackage

//--- verilog/plmc_cell.sv
`include "plmc_cfg.svh"

// Functional notes
// - combinational output picks one of four data inputs; low select AND, high select OR
// - sequential part reuses the full mux, feeding a latch or flip-flop store
// - anything the combinational cell does, the sequential cell does too
// - clear input from fabric forces the stored value to zero
// - store clock chosen from routed net zero, routed net one or array clock
// - array clock pad reaches the store through its pad filter only, independent of fanout
// - both external clock pads are buffered and also usable as plain inputs
// - each routed net picks pad first, pad second, internal first or internal second
module plmc_cell
  import plmc_pkg::*;
#(
  parameter plmc_store_mode_e STORE_MODE = PLMC_STORE_FLOP,
  parameter plmc_clk_sel_e    CLK_SEL    = PLMC_CLK_ARRAY,
  parameter plmc_net_src_e    NET0_SRC   = PLMC_SRC_PAD_FIRST,
  parameter plmc_net_src_e    NET1_SRC   = PLMC_SRC_PAD_SECOND
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sel_low_and_left_i,
  input  wire logic sel_low_and_right_i,
  input  wire logic sel_high_or_left_i,
  input  wire logic sel_high_or_right_i,
  input  wire logic mux_data_00_i,
  input  wire logic mux_data_01_i,
  input  wire logic mux_data_10_i,
  input  wire logic mux_data_11_i,
  input  wire logic storage_clear_input_i,
  input  wire logic external_clock_pad_first_i,
  input  wire logic external_clock_pad_second_i,
  input  wire logic array_clock_pad_i,
  input  wire logic internal_clock_source_first_i,
  input  wire logic internal_clock_source_second_i,
  output logic      comb_y_o,
  output logic      seq_q_o,
  output logic      routed_clock_net_zero_o,
  output logic      routed_clock_net_one_o,
  output logic      pad_first_level_o,
  output logic      pad_second_level_o
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // configuration is frozen at build time; nothing here can retarget it
  if (CLK_SEL != PLMC_CLK_NET_ZERO && CLK_SEL != PLMC_CLK_NET_ONE &&
      CLK_SEL != PLMC_CLK_ARRAY) begin : g_bad_clk_sel
    $error("plmc_cell: clock selection out of range");
  end

  // --------------------------------------------------------------------------
  // combinational cell
  // --------------------------------------------------------------------------
  logic select_low;
  logic select_high;
  logic [1:0] sel_pair;

  // two gated selects drive one four-way mux
  assign select_low  = sel_low_and_left_i & sel_low_and_right_i;
  assign select_high = sel_high_or_left_i | sel_high_or_right_i;
  assign sel_pair    = {select_high, select_low};
  assign comb_y_o    = sel_pair[1] ? (sel_pair[0] ? mux_data_11_i : mux_data_10_i)
                                   : (sel_pair[0] ? mux_data_01_i : mux_data_00_i);

  // --------------------------------------------------------------------------
  // pad filters
  // --------------------------------------------------------------------------
  logic [`PLMC_NUM_PADS-1:0] pad_raw;
  logic [`PLMC_NUM_PADS-1:0] pad_lvl;

  assign pad_raw[`PLMC_PAD_FIRST]  = external_clock_pad_first_i;
  assign pad_raw[`PLMC_PAD_SECOND] = external_clock_pad_second_i;
  assign pad_raw[`PLMC_PAD_ARRAY]  = array_clock_pad_i;

  // three stages; level moves only when stages two and three agree
  for (genvar p = 0; p < `PLMC_NUM_PADS; p++) begin : g_pad
    logic [`PLMC_SYNC_DEPTH-1:0] sync_q;
    logic                        lvl_q;
    logic                        lvl_d;

    assign lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sync_q <= `PLMC_SYNC_RST;
        lvl_q  <= `PLMC_LEVEL_RST;
      end else begin
        sync_q <= {sync_q[1:0], pad_raw[p]};
        lvl_q  <= lvl_d;
      end
    end
    assign pad_lvl[p] = lvl_q;
  end

  // pads read back as ordinary inputs when not clocking
  assign pad_first_level_o  = pad_lvl[`PLMC_PAD_FIRST];
  assign pad_second_level_o = pad_lvl[`PLMC_PAD_SECOND];

  // --------------------------------------------------------------------------
  // routed clock networks
  // --------------------------------------------------------------------------
  function automatic logic net_pick(input plmc_net_src_e src, input logic pa,
                                    input logic pb, input logic ia, input logic ib);
    unique case (src)
      PLMC_SRC_PAD_FIRST:  net_pick = pa;
      PLMC_SRC_PAD_SECOND: net_pick = pb;
      PLMC_SRC_INT_FIRST:  net_pick = ia;
      PLMC_SRC_INT_SECOND: net_pick = ib;
    endcase
  endfunction

  // same selector for both nets, so either may be used interchangeably
  assign routed_clock_net_zero_o = net_pick(NET0_SRC, pad_lvl[`PLMC_PAD_FIRST],
      pad_lvl[`PLMC_PAD_SECOND], internal_clock_source_first_i,
      internal_clock_source_second_i);
  assign routed_clock_net_one_o  = net_pick(NET1_SRC, pad_lvl[`PLMC_PAD_FIRST],
      pad_lvl[`PLMC_PAD_SECOND], internal_clock_source_first_i,
      internal_clock_source_second_i);

  // --------------------------------------------------------------------------
  // store clock selection and edge detect
  // --------------------------------------------------------------------------
  logic store_clk;
  logic store_clk_prev_q;
  logic store_clk_rise;

  // array clock has no selector in front, only the pad filter
  assign store_clk = (CLK_SEL == PLMC_CLK_NET_ZERO) ? routed_clock_net_zero_o :
                     (CLK_SEL == PLMC_CLK_NET_ONE)  ? routed_clock_net_one_o  :
                                                      pad_lvl[`PLMC_PAD_ARRAY];
  assign store_clk_rise = store_clk & ~store_clk_prev_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      store_clk_prev_q <= `PLMC_LEVEL_RST;
    end else begin
      store_clk_prev_q <= store_clk;
    end
  end

  // --------------------------------------------------------------------------
  // storage element
  // --------------------------------------------------------------------------
  logic store_load;
  logic store_d;
  logic store_q;

  // latch follows while clock high; flop takes the mux value on a rise only
  assign store_load = (STORE_MODE == PLMC_STORE_FLOP) ? store_clk_rise : store_clk;
  // clear outranks any load
  assign store_d = storage_clear_input_i ? `PLMC_STORE_RST :
                   store_load            ? comb_y_o : store_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      store_q <= `PLMC_STORE_RST;
    end else begin
      store_q <= store_d;
    end
  end
  assign seq_q_o = store_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_mux_low_only;
    (sel_low_and_left_i && sel_low_and_right_i && !sel_high_or_left_i &&
     !sel_high_or_right_i) |-> comb_y_o == mux_data_01_i;
  endproperty
  a_mux_low_only: assert property (p_mux_low_only)
    else $error("low select alone did not pick data 01");

  property p_mux_high_or;
    (sel_high_or_right_i && !(sel_low_and_left_i && sel_low_and_right_i))
      |-> comb_y_o == mux_data_10_i;
  endproperty
  a_mux_high_or: assert property (p_mux_high_or)
    else $error("high select alone did not pick data 10");

  property p_store_takes;
    (store_load && !storage_clear_input_i) |=> seq_q_o == $past(comb_y_o);
  endproperty
  a_store_takes: assert property (p_store_takes)
    else $error("store did not take the mux value");

  property p_store_holds;
    (!store_load && !storage_clear_input_i) |=> $stable(seq_q_o);
  endproperty
  a_store_holds: assert property (p_store_holds)
    else $error("store changed without a load");

  property p_clear_zero;
    storage_clear_input_i |=> !seq_q_o;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear did not zero the store");

  // watched through the ports: with CLK_SEL on routed net zero, a rising routed net zero must reach the store
  property p_clk_sel;
    (CLK_SEL == PLMC_CLK_NET_ZERO && $rose(routed_clock_net_zero_o) &&
     !storage_clear_input_i) |=> seq_q_o == $past(comb_y_o);
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("store clock not taken from the selected network");

  property p_array_pad_reach;
    array_clock_pad_i [*4] |=> pad_lvl[`PLMC_PAD_ARRAY];
  endproperty
  a_array_pad_reach: assert property (p_array_pad_reach)
    else $error("array clock level missed a steady pad");

  property p_pad_first_buf;
    !external_clock_pad_first_i [*4] |=> !pad_first_level_o;
  endproperty
  a_pad_first_buf: assert property (p_pad_first_buf)
    else $error("first pad level missed a steady low");

  property p_net_pick;
    routed_clock_net_zero_o ==
      ((NET0_SRC == PLMC_SRC_PAD_FIRST)  ? pad_first_level_o  :
       (NET0_SRC == PLMC_SRC_PAD_SECOND) ? pad_second_level_o :
       (NET0_SRC == PLMC_SRC_INT_FIRST)  ? internal_clock_source_first_i :
                                           internal_clock_source_second_i);
  endproperty
  a_net_pick: assert property (p_net_pick)
    else $error("routed net zero not from its chosen source");

  c_flop_capture: cover property (store_clk_rise && !storage_clear_input_i && comb_y_o);
  c_clear_hit:    cover property (seq_q_o ##1 storage_clear_input_i);
  c_mux_top:      cover property (select_low && select_high && mux_data_11_i);

endmodule // plmc_cell

//--- tb/plmc_fabric_model.sv
// ----------------------------------------------------------------------------
// fabric logic that drives the array clock pad
// ----------------------------------------------------------------------------
module plmc_fabric_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  output logic      pad_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] cnt_q;

  // one request gives a six cycle high phase; pad stands low between frames
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt_q <= 3'h0;
    else if (req_i) cnt_q <= 3'h6;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end

  assign pad_o = (cnt_q != 3'h0);
endmodule // plmc_fabric_model

//--- tb/plmc_cell_bench.sv
module plmc_cell_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [3:0] dat = 4'h0;
  logic       clr = 1'b0;
  logic       pad1 = 1'b0;
  logic       pad2 = 1'b0;
  logic       req = 1'b0;
  logic       ia = 1'b0;
  logic       ib = 1'b0;
  logic       hpad, y, q, n0, n1, l1, l2;
  logic       y2, q2, m0, m1;
  int         n_fail = 0;
  int         n_tests = 0;

  // ----------------------------------------------------------------------------
  // design and fabric model
  // ----------------------------------------------------------------------------
  plmc_cell dut_u (
    .clk_i(clk), .sys_rst_i(rst),
    .sel_low_and_left_i(sel[0]), .sel_low_and_right_i(sel[1]),
    .sel_high_or_left_i(sel[2]), .sel_high_or_right_i(sel[3]),
    .mux_data_00_i(dat[0]), .mux_data_01_i(dat[1]),
    .mux_data_10_i(dat[2]), .mux_data_11_i(dat[3]),
    .storage_clear_input_i(clr),
    .external_clock_pad_first_i(pad1), .external_clock_pad_second_i(pad2),
    .array_clock_pad_i(hpad),
    .internal_clock_source_first_i(ia), .internal_clock_source_second_i(ib),
    .comb_y_o(y), .seq_q_o(q),
    .routed_clock_net_zero_o(n0), .routed_clock_net_one_o(n1),
    .pad_first_level_o(l1), .pad_second_level_o(l2));

  // second cell: latch store clocked from routed net zero, nets from internal sources
  plmc_cell #(
    .STORE_MODE(plmc_pkg::PLMC_STORE_LATCH), .CLK_SEL(plmc_pkg::PLMC_CLK_NET_ZERO),
    .NET0_SRC(plmc_pkg::PLMC_SRC_INT_FIRST), .NET1_SRC(plmc_pkg::PLMC_SRC_INT_SECOND)
  ) dut_lat_u (
    .clk_i(clk), .sys_rst_i(rst),
    .sel_low_and_left_i(sel[0]), .sel_low_and_right_i(sel[1]),
    .sel_high_or_left_i(sel[2]), .sel_high_or_right_i(sel[3]),
    .mux_data_00_i(dat[0]), .mux_data_01_i(dat[1]),
    .mux_data_10_i(dat[2]), .mux_data_11_i(dat[3]),
    .storage_clear_input_i(clr),
    .external_clock_pad_first_i(pad1), .external_clock_pad_second_i(pad2),
    .array_clock_pad_i(hpad),
    .internal_clock_source_first_i(ia), .internal_clock_source_second_i(ib),
    .comb_y_o(y2), .seq_q_o(q2),
    .routed_clock_net_zero_o(m0), .routed_clock_net_one_o(m1),
    .pad_first_level_o(), .pad_second_level_o());

  plmc_fabric_model fab_u (.clk_i(clk), .rst_i(rst), .req_i(req), .pad_o(hpad));

  initial begin
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic pick(input logic [3:0] s, input logic [3:0] d);
    return d[{s[2] | s[3], s[0] & s[1]}];
  endfunction

  // inputs set, one array clock pulse, result read after the filter delay
  task automatic store(input logic [7:0] v, input logic c, input logic exp);
    {sel, dat} = v;
    clr = c;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    tick(9);
    check1("seq_q_o", exp, q);
    clr = 1'b0;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic test_comb();
    for (int i = 0; i < 256; i++) begin
      tick(1);
      {sel, dat} = i[7:0];
      #1;
      check1("comb_y_o", pick(sel, dat), y);
    end
    $display("done comb sweep");
  endtask

  task automatic test_store();
    store(8'h3_2, 1'b0, 1'b1);
    store(8'h3_d, 1'b0, 1'b0);
    store(8'h4_4, 1'b0, 1'b1);
    store(8'hf_8, 1'b1, 1'b0);
    $display("done store via array clock");
  endtask

  task automatic test_clear();
    store(8'h3_a, 1'b0, 1'b1);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    check1("seq_q_o", 1'b0, q);
    tick(3);
    check1("seq_q_o", 1'b0, q);
    $display("done clear");
  endtask

  task automatic test_pads();
    pad1 = 1'b1;
    pad2 = 1'b0;
    tick(6);
    check1("pad_first_level_o", 1'b1, l1);
    check1("pad_second_level_o", 1'b0, l2);
    check1("routed_clock_net_zero_o", 1'b1, n0);
    check1("routed_clock_net_one_o", 1'b0, n1);
    pad1 = 1'b0;
    pad2 = 1'b1;
    tick(6);
    check1("pad_first_level_o", 1'b0, l1);
    check1("pad_second_level_o", 1'b1, l2);
    check1("routed_clock_net_zero_o", 1'b0, n0);
    check1("routed_clock_net_one_o", 1'b1, n1);
    // a one-cycle spike never gets stages two and three to agree
    pad1 = 1'b1;
    tick(1);
    pad1 = 1'b0;
    repeat (5) begin
      tick(1);
      check1("pad_first_level_o", 1'b0, l1);
    end
    $display("done pads");
  endtask

  // latch cell: open while internal source first is high, holds while low
  task automatic test_latch();
    ia = 1'b0;
    ib = 1'b1;
    {sel, dat} = 8'h3_2;
    tick(1);
    check1("latch routed_clock_net_zero_o", 1'b0, m0);
    check1("latch routed_clock_net_one_o", 1'b1, m1);
    check1("latch comb_y_o", 1'b1, y2);
    check1("latch seq_q_o", 1'b0, q2);
    ia = 1'b1;
    tick(1);
    check1("latch routed_clock_net_zero_o", 1'b1, m0);
    check1("latch seq_q_o", 1'b1, q2);
    clr = 1'b1;
    tick(1);
    check1("latch seq_q_o", 1'b0, q2);
    clr = 1'b0;
    tick(1);
    check1("latch seq_q_o", 1'b1, q2);
    {sel, dat} = 8'h3_d;
    tick(1);
    check1("latch seq_q_o", 1'b0, q2);
    ia = 1'b0;
    ib = 1'b0;
    {sel, dat} = 8'h3_2;
    tick(1);
    check1("latch seq_q_o", 1'b0, q2);
    check1("latch routed_clock_net_one_o", 1'b0, m1);
    $display("done latch");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under 1000 cycles
  initial begin
    #100_000;
    n_fail++;
    print_verdict();
  end

  initial begin
    tick(10);
    check1("seq_q_o", 1'b0, q);
    rst = 1'b0;
    test_comb();
    test_store();
    test_clear();
    test_pads();
    test_latch();
    print_verdict();
  end
endmodule // plmc_cell_bench
